// ---- logic/rhc_pkg.sv ----
package rhc_pkg;
  // Core timing at the reference clock
  localparam int CLK_MHZ = 100;
  localparam int POR_TIME_US = 1000;
  localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
  localparam int CMD_BUSY_CYCLES = 16;
  localparam int EVENT_W = 8;
  localparam int GPIO_OTHER_W = 3;
  // Serial command codes and answers
  localparam logic [7:0] CMD_READ_CTS = 8'h44;
  localparam logic [7:0] CMD_INT_STATUS = 8'h20;
  localparam logic [7:0] CTS_READY = 8'hFF;
  localparam logic [7:0] CTS_BUSY = 8'h00;
  localparam logic [3:0] BIT_LAST_CMD = 4'h7;
  localparam logic [3:0] BIT_SAT = 4'hF;
  // Values after reset
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [EVENT_W-1:0] PENDING_RST = 8'h00;

  typedef enum logic [1:0] {
    ST_SHUT = 2'b00,
    ST_POR = 2'b01,
    ST_IDLE = 2'b10,
    ST_BUSY = 2'b11
  } rhc_state_t;

  // Status handed from the core to the serial side
  typedef struct packed {
    logic cts;
    logic [EVENT_W-1:0] pending;
  } rhc_status_t;
endpackage

// ---- logic/rhc_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// RULE1: Shutdown high holds device fully disabled; the serial slave still drives serial_out_pin while selected.
// RULE2: Shutdown release triggers complete power-on reset.
// RULE3: Commands accepted about 1 ms after release.
// RULE4: Ready pin high once commands accepted.
// RULE5: All general purpose pins driven low in shutdown.
// RULE6: Active-low interrupt pin flags enabled pending events.
// RULE7: Reading interrupt status clears flag, releases pin.
// RULE8: Four-wire serial slave; host clocks and selects.
// RULE9: Code 0x44 returns 0xFF when ready.
// RULE10: Ready pin reflects command completion after reset.
// RULE11: Host waits for ready pin before transactions.
module rhc_top import rhc_pkg::*; #(
  parameter int POR_CNT = POR_CYCLES,
  parameter int BUSY_CNT = CMD_BUSY_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic shutdown_pin,
  input wire logic spi_clk,
  input wire logic select_n_pin,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic interrupt_n_pin,
  output logic ready_indicator_pin,
  output logic ready_indicator_oe,
  output logic [GPIO_OTHER_W-1:0] gpio_out,
  output logic [GPIO_OTHER_W-1:0] gpio_oe,
  input wire logic [EVENT_W-1:0] event_in,
  input wire logic [EVENT_W-1:0] int_enable
);
  localparam int CNT_W = $clog2(POR_CNT + BUSY_CNT + 1);

  // ---------------- Core domain ----------------
  logic sdn_s1, sdn_s2, sel_s1, sel_s2;
  logic tog_s1, tog_s2, tog_s3;
  logic cmd_evt;
  // Command word and its toggle are written by the serial side and read here after the toggle syncs
  logic [7:0] cmd_code, next_cmd_code;
  logic cmd_tog, next_cmd_tog;
  rhc_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [EVENT_W-1:0] pending, next_pending;
  rhc_status_t snap, next_snap;
  logic next_irq_n, next_ready, next_gpio_oe;
  logic gpio_oe_bit;

  // Pin and cross-domain synchronisers; first stages feed only second stages
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sdn_s1 <= 1'b1;
      sdn_s2 <= 1'b1;
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else begin
      sdn_s1 <= shutdown_pin;
      sdn_s2 <= sdn_s1;
      sel_s1 <= select_n_pin;
      sel_s2 <= sel_s1;
      tog_s1 <= cmd_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  // One pulse per received command byte
  assign cmd_evt = tog_s2 ^ tog_s3;

  // Power state machine and command processing time
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ST_SHUT: begin
        next_state = ST_POR; // see RULE2
        next_cnt = CNT_W'(POR_CNT - 1); // see RULE3
      end
      ST_POR: begin
        if (cnt == '0) begin
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_IDLE: begin
        // Status reads are answered at once and never make the core busy
        if (cmd_evt && cmd_code != CMD_READ_CTS && cmd_code != CMD_INT_STATUS) begin
          next_state = ST_BUSY;
          next_cnt = CNT_W'(BUSY_CNT - 1);
        end
      end
      ST_BUSY: begin
        if (cnt == '0) begin
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = ST_SHUT;
      end
    endcase
    if (sdn_s2) begin
      next_state = ST_SHUT; // see RULE1
      next_cnt = '0;
    end
  end

  // Pending flags: a new event wins over a clear in the same cycle
  always_comb begin
    next_pending = pending;
    if (state == ST_SHUT || state == ST_POR) begin
      next_pending = PENDING_RST; // see RULE2
    end else begin
      if (cmd_evt && cmd_code == CMD_INT_STATUS) begin
        next_pending = pending & ~snap.pending; // see RULE7
      end
      next_pending = next_pending | event_in;
    end
  end

  // Snapshot only changes while select is idle, so the serial side sees stable bits
  always_comb begin
    next_snap = snap;
    if (sel_s2) begin
      next_snap.cts = (state == ST_IDLE);
      next_snap.pending = pending;
    end
  end

  // Pin levels
  always_comb begin
    next_irq_n = ~|(pending & int_enable); // see RULE6
    next_ready = (state == ST_IDLE); // see RULE4 RULE10
    next_gpio_oe = (state == ST_SHUT); // see RULE5
    if (state == ST_SHUT) begin
      next_irq_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_SHUT;
      cnt <= '0;
      pending <= PENDING_RST;
      snap <= '0;
      interrupt_n_pin <= 1'b1;
      ready_indicator_pin <= 1'b0;
      gpio_oe_bit <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pending <= next_pending;
      snap <= next_snap;
      interrupt_n_pin <= next_irq_n;
      ready_indicator_pin <= next_ready;
      gpio_oe_bit <= next_gpio_oe;
    end
  end

  // Ready pin is always driven: low in shutdown and reset, status otherwise
  assign ready_indicator_oe = 1'b1; // see RULE5
  assign gpio_out = '0;
  assign gpio_oe = {GPIO_OTHER_W{gpio_oe_bit}};

  // ---------------- Serial link domain ----------------
  // Select high resets the frame logic, so a clock that stops between frames is harmless
  logic frame_rst;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [6:0] shift, next_shift;
  logic [7:0] resp, next_resp;
  rhc_status_t stat_s1, stat_s2;
  logic [7:0] rx_byte;

  assign frame_rst = rst | select_n_pin;
  assign rx_byte = {shift, serial_in_pin};

  // Bit counter, command shifter and answer byte
  always_comb begin
    next_bit_cnt = (bit_cnt == BIT_SAT) ? bit_cnt : bit_cnt + 1'b1;
    next_shift = rx_byte[6:0]; // see RULE8
    next_resp = resp;
    if (bit_cnt == BIT_LAST_CMD) begin
      if (rx_byte == CMD_READ_CTS) begin
        next_resp = stat_s2.cts ? CTS_READY : CTS_BUSY; // see RULE9
      end else if (rx_byte == CMD_INT_STATUS) begin
        next_resp = stat_s2.pending; // see RULE7
      end else begin
        next_resp = CTS_BUSY;
      end
    end
  end

  always_ff @(posedge spi_clk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt <= '0;
      shift <= '0;
      resp <= '0;
    end else begin
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      resp <= next_resp;
    end
  end

  // Command word and toggle survive the frame end so the core can read them later
  always_comb begin
    next_cmd_code = cmd_code;
    next_cmd_tog = cmd_tog;
    if (bit_cnt == BIT_LAST_CMD) begin
      next_cmd_code = rx_byte;
      next_cmd_tog = ~cmd_tog;
    end
  end

  always_ff @(posedge spi_clk or posedge rst) begin
    if (rst) begin
      cmd_code <= CMD_RST;
      cmd_tog <= 1'b0;
      stat_s1 <= '0;
      stat_s2 <= '0;
    end else begin
      cmd_code <= next_cmd_code;
      cmd_tog <= next_cmd_tog;
      stat_s1 <= snap;
      stat_s2 <= stat_s1;
    end
  end

  // Answer bits change on the falling edge, MSB first, for sampling on the rising edge
  always_ff @(negedge spi_clk or posedge frame_rst) begin
    if (frame_rst) begin
      serial_out_pin <= 1'b0;
    end else if (bit_cnt[3]) begin
      serial_out_pin <= resp[~bit_cnt[2:0]]; // see RULE9
    end else begin
      serial_out_pin <= 1'b0;
    end
  end

  assign serial_out_oe = ~select_n_pin; // see RULE8
endmodule

// ---- tb/rhc_sva.sv ----
`timescale 1ns/1ps
module rhc_sva import rhc_pkg::*; #(
  parameter int POR_CNT = 50
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic shutdown_pin,
  input wire logic select_n_pin,
  input wire logic serial_out_oe,
  input wire logic interrupt_n_pin,
  input wire logic ready_indicator_pin,
  input wire logic ready_indicator_oe,
  input wire logic [GPIO_OTHER_W-1:0] gpio_out,
  input wire logic [GPIO_OTHER_W-1:0] gpio_oe,
  input wire logic [EVENT_W-1:0] event_in,
  input wire logic [EVENT_W-1:0] int_enable
);
  localparam int PMAX = POR_CNT + 8;
  // All checks live in the core domain
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Two sync stages, one state edge and one output edge pass before the pins settle
  property p_shut; shutdown_pin [*5] |-> !ready_indicator_pin && interrupt_n_pin && gpio_oe == 3'h7; endproperty
  a_shut: assert property (p_shut) else $error("shutdown state");
  property p_gpio; gpio_out == 3'h0; endproperty
  a_gpio: assert property (p_gpio) else $error("gpio level");
  property p_oe; ready_indicator_oe && serial_out_oe == !select_n_pin; endproperty
  a_oe: assert property (p_oe) else $error("pin enables");
  property p_por_min; $fell(shutdown_pin) ##POR_CNT 1 |-> !ready_indicator_pin; endproperty
  a_por_min: assert property (p_por_min) else $error("ready early");
  property p_por_max; $fell(shutdown_pin) |-> ##[1:PMAX] ready_indicator_pin; endproperty
  a_por_max: assert property (p_por_max) else $error("ready late");
  property p_irq; |(event_in & int_enable) && ready_indicator_pin && !shutdown_pin |-> ##[1:3] !interrupt_n_pin;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_irq_rel; $rose(interrupt_n_pin) |-> !select_n_pin || $past(shutdown_pin, 2); endproperty
  a_irq_rel: assert property (p_irq_rel) else $error("irq released");
  property p_rdy_fall; $fell(ready_indicator_pin) |-> !select_n_pin || $past(shutdown_pin, 2); endproperty
  a_rdy_fall: assert property (p_rdy_fall) else $error("ready dropped");
  // Main scenarios reached
  c_ready: cover property ($rose(ready_indicator_pin));
  c_irq: cover property ($fell(interrupt_n_pin));
  c_clear: cover property ($rose(interrupt_n_pin) && !select_n_pin);
endmodule
bind rhc_top rhc_sva #(.POR_CNT(POR_CNT)) u_sva (.ref_clk, .rst, .shutdown_pin, .select_n_pin, .serial_out_oe,
  .interrupt_n_pin, .ready_indicator_pin, .ready_indicator_oe, .gpio_out, .gpio_oe, .event_in, .int_enable);

// ---- tb/rhc_host.sv ----
`timescale 1ns/1ps
module rhc_host (
  output logic spi_clk,
  output logic select_n_pin,
  output logic serial_in_pin,
  input wire logic serial_out_pin
);
  // Clock stands low and select high between frames
  initial begin
    spi_clk = 1'b0;
    select_n_pin = 1'b1;
    serial_in_pin = 1'b0;
  end
  // One frame, mode 0, MSB first: command out, answer in
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] ans);
    #7 select_n_pin = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_in_pin = (i > 7) ? cmd[i-8] : ~serial_in_pin;
      #24 spi_clk = 1'b1;
      if (i < 8)
        ans[i] = serial_out_pin;
      #24 spi_clk = 1'b0;
    end
    #24 select_n_pin = 1'b1;
    serial_in_pin = ~serial_in_pin; // Released line shows no stale bit
    #60; // Gap lets the status snapshot refresh
  endtask
endmodule

// ---- tb/rhc_top_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module rhc_top_tb_top import rhc_pkg::*;;
  localparam int P = 50;
  logic ref_clk, rst, shutdown_pin, spi_clk, select_n_pin, serial_in_pin, serial_out_pin;
  logic interrupt_n_pin, ready_indicator_pin;
  logic [EVENT_W-1:0] event_in, int_enable, ans, pend;
  logic [GPIO_OTHER_W-1:0] gpio_oe;
  int error_cnt = 0, check_count = 0, n, seed = 36;
  // Long busy time keeps the refusal visible across a whole frame
  rhc_top #(.POR_CNT(P), .BUSY_CNT(300)) dut (.ref_clk, .rst, .shutdown_pin, .spi_clk, .select_n_pin,
    .serial_in_pin, .serial_out_pin, .serial_out_oe(), .interrupt_n_pin, .ready_indicator_pin,
    .ready_indicator_oe(), .gpio_out(), .gpio_oe, .event_in, .int_enable);
  rhc_host host (.spi_clk, .select_n_pin, .serial_in_pin, .serial_out_pin);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cycles(int k);
    repeat (k) @(negedge ref_clk);
  endtask
  // Bounded wait for the ready pin; a hang ends the run
  task automatic wait_ready();
    for (n = 0; n < 400 && ready_indicator_pin !== 1'b1; n++)
      @(negedge ref_clk);
    if (ready_indicator_pin !== 1'b1) begin
      error_cnt++;
      final_report();
    end
  endtask
  initial begin
    rst = 1'b1;
    shutdown_pin = 1'b1;
    event_in = 8'h01;
    int_enable = 8'hFF;
    pend = 8'h00;
    cycles(16);
    rst = 1'b0;
    cycles(6);
    event_in = 8'h00;
    `CHK("irq_shut", 1'b1, interrupt_n_pin)
    `CHK("gpio_shut", 3'h7, gpio_oe)
    $display("test shutdown done");
    for (int r = 0; r < 2; r++) begin
      shutdown_pin = 1'b0;
      wait_ready();
      `CHK("por_time", 1'b1, n >= P && n <= P + 8)
      host.xfer(CMD_INT_STATUS, ans);
      `CHK("por_clear", 8'h00, ans)
      // Mask changes only while nothing is pending, so the pin releases only on a status read or in shutdown
      cycles(1);
      int_enable = EVENT_W'($random(seed));
      repeat (3) begin
        cycles(1);
        event_in = EVENT_W'($random(seed));
        pend |= event_in;
        cycles(1);
        event_in = 8'h00;
        cycles(4);
        `CHK("irq", ~|(pend & int_enable), interrupt_n_pin)
        host.xfer(CMD_READ_CTS, ans);
        `CHK("cts", CTS_READY, ans)
      end
      host.xfer(CMD_INT_STATUS, ans);
      `CHK("status", pend, ans)
      pend = 8'h00;
      `CHK("irq_rel", 1'b1, interrupt_n_pin)
      host.xfer(8'h13, ans);
      `CHK("busy_pin", 1'b0, ready_indicator_pin)
      host.xfer(CMD_READ_CTS, ans);
      `CHK("cts_busy", CTS_BUSY, ans)
      wait_ready();
      cycles(1);
      event_in = 8'h81;
      int_enable = 8'hFF;
      cycles(1);
      event_in = 8'h00;
      shutdown_pin = 1'b1;
      cycles(5);
      `CHK("shut_irq", 1'b1, interrupt_n_pin)
      `CHK("shut_rdy", 1'b0, ready_indicator_pin)
      `CHK("shut_gpio", 3'h7, gpio_oe)
      $display("test pass %0d done", r);
    end
    final_report();
  end
endmodule
